// *** verilog/cin_pkg.sv ***
`default_nettype none
package cin_pkg;

  localparam int NUM_INST = 10;
  localparam int INST_W = 4;
  localparam int NUM_SIG = 4;
  localparam int SIG_W = 2;
  localparam int NUM_EVT = NUM_INST * NUM_SIG;
  localparam int EVT_IDX_W = 6;
  localparam int DI_W = 32;
  localparam int SW_W = 32;
  localparam int SEL_W = 5;
  localparam int STAMP_W = 32;

  // Label storage
  localparam int LABEL_LEN = 32;
  localparam int LABEL_IDX_W = 5;
  localparam int CHAR_W = 8;
  localparam int LABEL_CELLS = NUM_INST * LABEL_LEN;
  localparam logic [CHAR_W-1:0] LBL_CH0 = 8'h49;
  localparam logic [CHAR_W-1:0] LBL_CH1 = 8'h4E;
  localparam logic [CHAR_W-1:0] LBL_CH2 = 8'h44;
  localparam logic [CHAR_W-1:0] LBL_DIGIT0 = 8'h30;
  localparam logic [CHAR_W-1:0] LBL_DIGIT1 = 8'h31;
  localparam logic [CHAR_W-1:0] LBL_PAD = 8'h20;

  // Time base
  localparam int CLK_HZ = 25_000_000;
  localparam int STAMP_RES_MS = 1;
  localparam int MS_CYCLES_DEF = CLK_HZ / 1000 * STAMP_RES_MS;
  localparam int DIV_W = 16;

  // Signal slot inside an instance's one-hot state word
  localparam int SIG_INTER = 0;
  localparam int SIG_OPEN = 1;
  localparam int SIG_CLOSE = 2;
  localparam int SIG_BAD = 3;
  localparam logic [NUM_SIG-1:0] STATE_RST = 4'h1;
  localparam logic [NUM_SIG-1:0] EN_RST = 4'hF;

  typedef enum logic [1:0] {
    POS_INTER,
    POS_OPEN,
    POS_CLOSED,
    POS_BAD
  } cin_pos_type;

  typedef struct packed {
    logic open_is_sw;
    logic [SEL_W-1:0] open_idx;
    logic close_is_sw;
    logic [SEL_W-1:0] close_idx;
    logic [NUM_SIG-1:0] on_en;
    logic [NUM_SIG-1:0] off_en;
  } cin_cfg_type;

  typedef struct packed {
    logic [INST_W-1:0] inst;
    logic [SIG_W-1:0] sig;
    logic on;
    logic [STAMP_W-1:0] stamp;
  } cin_evt_type;

endpackage
`default_nettype wire

// *** verilog/cin_ind_unit.sv ***
`timescale 1ns/100ps
`default_nettype none
module cin_ind_unit
  import cin_pkg::*;
(
  input wire logic clock, // System clock
  input wire logic rst_n, // Synchronised reset, active low
  input wire logic [DI_W-1:0] di, // Physical digital inputs
  input wire logic [SW_W-1:0] software_signal, // Internal logic signals
  input wire cin_cfg_type cfg, // Static configuration
  output logic [NUM_SIG-1:0] state_o, // One-hot state
  output logic [NUM_SIG-1:0] rise_o, // Per-signal activation pulse
  output logic [NUM_SIG-1:0] fall_o // Per-signal deactivation pulse
);

  logic open_in;
  logic close_in;
  cin_pos_type pos;
  logic [NUM_SIG-1:0] nxt_state;
  logic [NUM_SIG-1:0] state_ff;
  logic [NUM_SIG-1:0] rise_ff;
  logic [NUM_SIG-1:0] fall_ff;

  assign open_in = cfg.open_is_sw ? software_signal[cfg.open_idx] : di[cfg.open_idx];
  assign close_in = cfg.close_is_sw ? software_signal[cfg.close_idx] : di[cfg.close_idx];

  always_comb begin
    case ({open_in, close_in})
      2'b10: pos = POS_OPEN;
      2'b01: pos = POS_CLOSED;
      2'b11: pos = POS_BAD;
      default: pos = POS_INTER;
    endcase
    nxt_state = STATE_RST << pos;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= STATE_RST;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Edges leave together with the new state so both describe the same sample
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rise_ff <= '0;
      fall_ff <= '0;
    end else begin
      rise_ff <= nxt_state & ~state_ff;
      fall_ff <= state_ff & ~nxt_state;
    end
  end

  assign state_o = state_ff;
  assign rise_o = rise_ff;
  assign fall_o = fall_ff;

endmodule // cin_ind_unit
`default_nettype wire

// *** verilog/cin_monitor.sv ***
`timescale 1ns/100ps
`default_nettype none
module cin_monitor
  import cin_pkg::*;
#(
  parameter int MS_CYCLES = MS_CYCLES_DEF
) (
  input wire logic clock, // 25 MHz system clock
  input wire logic nrst, // Asynchronous reset, active low
  input wire logic setup_mode, // High while the function is in setup
  input wire logic cfg_wr, // Configuration write strobe
  input wire logic [INST_W-1:0] cfg_inst, // Instance to configure
  input wire cin_cfg_type cfg_data, // Configuration word
  input wire logic [DI_W-1:0] di, // Physical digital inputs
  input wire logic [SW_W-1:0] software_signal, // Internal logic signals
  input wire logic label_wr, // Label character write strobe
  input wire logic [INST_W-1:0] label_inst, // Instance of written label
  input wire logic [LABEL_IDX_W-1:0] label_idx, // Character position written
  input wire logic [CHAR_W-1:0] label_char, // Character written
  input wire logic [INST_W-1:0] label_rd_inst, // Instance of read label
  input wire logic [LABEL_IDX_W-1:0] label_rd_idx, // Character position read
  output logic [CHAR_W-1:0] label_rd_char, // Character read, one cycle later
  output logic [NUM_INST-1:0][NUM_SIG-1:0] ind_state, // One-hot states per instance
  output logic evt_valid, // Event offered to the event buffer
  input wire logic evt_ready, // Event buffer accepts
  output cin_evt_type evt_data, // Offered event
  output logic [STAMP_W-1:0] ms_time // Running millisecond count
);

  // Default label length: three letters and up to two digits
  localparam int LBL_DFLT_LEN = 5;

  // Reset and time base
  logic rst_meta_ff;
  logic rst_sync_ff;
  logic [DIV_W-1:0] div_ff;
  logic ms_tick;
  logic [STAMP_W-1:0] ms_time_ff;

  // Configuration and decode
  logic cfg_take;
  cin_cfg_type cfg_ff [NUM_INST];
  logic [NUM_INST-1:0][NUM_SIG-1:0] rise;
  logic [NUM_INST-1:0][NUM_SIG-1:0] fall;
  logic [NUM_EVT-1:0] set_on;
  logic [NUM_EVT-1:0] set_any;
  logic [NUM_EVT-1:0] pend_ff;
  logic [NUM_EVT-1:0] pol_ff;
  logic [STAMP_W-1:0] stamp_ff [NUM_EVT];

  // Event queue
  logic grant_any;
  logic [EVT_IDX_W-1:0] grant_idx;
  logic take;
  logic evt_valid_ff;
  cin_evt_type evt_ff;

  // Label store
  logic label_take;
  logic [CHAR_W-1:0] label_mem [LABEL_CELLS];
  logic [LABEL_CELLS-1:0] lbl_vld_ff;
  logic [NUM_INST-1:0] lbl_named_ff;
  logic [CHAR_W-1:0] dflt_lbl [NUM_INST][LBL_DFLT_LEN];
  logic [CHAR_W-1:0] label_rd_ff;
  logic [CHAR_W-1:0] nxt_label_rd;
  logic [8:0] lbl_wr_cell;
  logic [8:0] lbl_rd_cell;

  // Reset release through two flops
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  // Millisecond time base
  assign ms_tick = (div_ff == DIV_W'(MS_CYCLES - 1));

  always_ff @(posedge clock or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      div_ff <= '0;
    end else if (ms_tick) begin
      div_ff <= '0;
    end else begin
      div_ff <= div_ff + 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      ms_time_ff <= '0;
    end else if (ms_tick) begin
      ms_time_ff <= ms_time_ff + 1'b1;
    end
  end

  assign cfg_take = setup_mode && cfg_wr && (cfg_inst < INST_W'(NUM_INST));

  // Configuration is frozen outside setup so the decoders never see a half-changed selection
  always_ff @(posedge clock or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      for (int i = 0; i < NUM_INST; i++) begin
        cfg_ff[i].open_is_sw <= 1'b0;
        cfg_ff[i].open_idx <= SEL_W'(2 * i);
        cfg_ff[i].close_is_sw <= 1'b0;
        cfg_ff[i].close_idx <= SEL_W'(2 * i + 1);
        cfg_ff[i].on_en <= EN_RST;
        cfg_ff[i].off_en <= EN_RST;
      end
    end else if (cfg_take) begin
      cfg_ff[cfg_inst] <= cfg_data;
    end
  end

  // One decoder per instance; none of them has a command path
  for (genvar g = 0; g < NUM_INST; g++) begin : g_inst
    cin_ind_unit u_unit (
      .clock(clock),
      .rst_n(rst_sync_ff),
      .di(di),
      .software_signal(software_signal),
      .cfg(cfg_ff[g]),
      .state_o(ind_state[g]),
      .rise_o(rise[g]),
      .fall_o(fall[g])
    );
    for (genvar s = 0; s < NUM_SIG; s++) begin : g_sig
      assign set_on[g*NUM_SIG+s] = rise[g][s] & cfg_ff[g].on_en[s];
      assign set_any[g*NUM_SIG+s] = set_on[g*NUM_SIG+s] | (fall[g][s] & cfg_ff[g].off_en[s]);
    end
  end

  // Lowest pending slot wins
  always_comb begin
    grant_any = 1'b0;
    grant_idx = '0;
    for (int k = NUM_EVT - 1; k >= 0; k--) begin
      if (pend_ff[k]) begin
        grant_any = 1'b1;
        grant_idx = EVT_IDX_W'(k);
      end
    end
  end

  assign take = grant_any && (!evt_valid_ff || evt_ready);

  // A newer edge on a still-pending slot replaces the older one: latest state wins
  // One slot per signal keeps the queue small; a long stall costs the older edge
  always_ff @(posedge clock or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      pend_ff <= '0;
    end else begin
      for (int k = 0; k < NUM_EVT; k++) begin
        if (set_any[k]) begin
          pend_ff[k] <= 1'b1;
        end else if (take && (grant_idx == EVT_IDX_W'(k))) begin
          pend_ff[k] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clock or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      pol_ff <= '0;
    end else begin
      for (int k = 0; k < NUM_EVT; k++) begin
        if (set_any[k]) begin
          pol_ff[k] <= set_on[k];
        end
      end
    end
  end

  always_ff @(posedge clock or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      for (int k = 0; k < NUM_EVT; k++) begin
        stamp_ff[k] <= '0;
      end
    end else begin
      for (int k = 0; k < NUM_EVT; k++) begin
        if (set_any[k]) begin
          stamp_ff[k] <= ms_time_ff;
        end
      end
    end
  end

  // Valid drops only once the buffer has taken the event
  always_ff @(posedge clock or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      evt_valid_ff <= 1'b0;
    end else if (take) begin
      evt_valid_ff <= 1'b1;
    end else if (evt_ready) begin
      evt_valid_ff <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      evt_ff <= '0;
    end else if (take) begin
      evt_ff.inst <= INST_W'(grant_idx / EVT_IDX_W'(NUM_SIG));
      evt_ff.sig <= grant_idx[SIG_W-1:0];
      evt_ff.on <= pol_ff[grant_idx];
      evt_ff.stamp <= stamp_ff[grant_idx];
    end
  end

  // Label storage; unwritten cells of a named label read as blanks
  assign lbl_wr_cell = 9'(label_inst * LABEL_LEN) + 9'(label_idx);
  assign lbl_rd_cell = 9'(label_rd_inst * LABEL_LEN) + 9'(label_rd_idx);
  assign label_take = setup_mode && label_wr && (label_inst < INST_W'(NUM_INST));

  // No reset on the character array; the valid bits decide what is shown
  always_ff @(posedge clock) begin
    if (label_take) begin
      label_mem[lbl_wr_cell] <= label_char;
    end
  end

  always_ff @(posedge clock or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      lbl_vld_ff <= '0;
    end else if (label_take) begin
      lbl_vld_ff[lbl_wr_cell] <= 1'b1;
    end
  end

  // One flag per instance: the first written character replaces the whole default text
  always_ff @(posedge clock or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      lbl_named_ff <= '0;
    end else if (label_take) begin
      lbl_named_ff[label_inst] <= 1'b1;
    end
  end

  // Default text per instance: three letters, then the instance number counted from one
  for (genvar g = 0; g < NUM_INST; g++) begin : g_dflt
    assign dflt_lbl[g][0] = LBL_CH0;
    assign dflt_lbl[g][1] = LBL_CH1;
    assign dflt_lbl[g][2] = LBL_CH2;
    if (g < 9) begin : g_one
      assign dflt_lbl[g][3] = LBL_DIGIT1 + CHAR_W'(g);
      assign dflt_lbl[g][4] = LBL_PAD;
    end else begin : g_two
      assign dflt_lbl[g][3] = LBL_DIGIT1 + CHAR_W'(g - 9);
      assign dflt_lbl[g][4] = LBL_DIGIT0;
    end
  end

  always_comb begin
    nxt_label_rd = LBL_PAD;
    if (label_rd_inst >= INST_W'(NUM_INST)) begin
      nxt_label_rd = LBL_PAD;
    end else if (lbl_named_ff[label_rd_inst]) begin
      nxt_label_rd = lbl_vld_ff[lbl_rd_cell] ? label_mem[lbl_rd_cell] : LBL_PAD;
    end else if (label_rd_idx < LABEL_IDX_W'(LBL_DFLT_LEN)) begin
      nxt_label_rd = dflt_lbl[label_rd_inst][label_rd_idx[2:0]];
    end
  end

  always_ff @(posedge clock or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      label_rd_ff <= LBL_PAD;
    end else begin
      label_rd_ff <= nxt_label_rd;
    end
  end

  assign label_rd_char = label_rd_ff;
  assign evt_valid = evt_valid_ff;
  assign evt_data = evt_ff;
  assign ms_time = ms_time_ff;

endmodule // cin_monitor
`default_nettype wire

// *** bench/cin_contacts.sv ***
`timescale 1ns/100ps
`default_nettype none
module cin_contacts
  import cin_pkg::*;
(
  input wire logic [1:0] pos, // Pair of instance 1: bit0 open, bit1 closed
  input wire logic single, // Lone contact of instance 2
  output logic [DI_W-1:0] di, // Digital inputs
  output logic [SW_W-1:0] software_signal // Logic editor outputs
);
  assign di = {29'h0, single, pos};
  // Inverted copy is 1 while the lone contact is 0
  assign software_signal = {31'h0, ~single};
endmodule // cin_contacts
`default_nettype wire

// *** bench/cin_monitor_chk.sv ***
`timescale 1ns/100ps
`default_nettype none
module cin_monitor_chk
  import cin_pkg::*;
#(
  parameter int MS_CYCLES = MS_CYCLES_DEF
) (
  input wire logic clock, // Clock
  input wire logic nrst, // Reset, active low
  input wire logic [DI_W-1:0] di, // Inputs
  input wire logic [NUM_INST-1:0][NUM_SIG-1:0] ind_state, // States
  input wire logic evt_valid, // Offered
  input wire logic evt_ready, // Taken
  input wire cin_evt_type evt_data, // Event
  input wire logic [STAMP_W-1:0] ms_time // Time
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  logic [2:0] up_ff;
  logic hot;
  // Decode checks wait out the reset synchroniser
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) up_ff <= 3'h0;
    else up_ff <= {up_ff[1:0], 1'b1};
  end
  always_comb begin
    hot = 1'b1;
    for (int i = 0; i < NUM_INST; i++) hot &= $onehot(ind_state[i]);
  end
  property p_open; up_ff[2] && di[1:0] == 2'h1 |=> ind_state[0] == 4'h2; endproperty
  a_open: assert property (p_open) else $error("open decode wrong");
  property p_close; up_ff[2] && di[1:0] == 2'h2 |=> ind_state[0] == 4'h4; endproperty
  a_close: assert property (p_close) else $error("closed decode wrong");
  property p_inter; up_ff[2] && di[1:0] == 2'h0 |=> ind_state[0] == 4'h1; endproperty
  a_inter: assert property (p_inter) else $error("intermediate decode wrong");
  property p_bad; $past(up_ff[2]) && $past(di[1:0]) == 2'h3 |-> ind_state[0] == 4'h8; endproperty
  a_bad: assert property (p_bad) else $error("bad decode wrong");
  property p_hot; hot; endproperty
  a_hot: assert property (p_hot) else $error("state not one-hot");
  property p_hold; evt_valid && !evt_ready |=> evt_valid && $stable(evt_data); endproperty
  a_hold: assert property (p_hold) else $error("event dropped while stalled");
  property p_inst; evt_valid |-> evt_data.inst < NUM_INST; endproperty
  a_inst: assert property (p_inst) else $error("event instance out of range");
  property p_step; ms_time != $past(ms_time) |-> ms_time == $past(ms_time) + 32'h1; endproperty
  a_step: assert property (p_step) else $error("time step not one");
  property p_gap; ms_time != $past(ms_time) && ms_time > 32'h2 |-> $past(ms_time, MS_CYCLES) == ms_time - 32'h1;
  endproperty
  a_gap: assert property (p_gap) else $error("time tick period wrong");
  c_take: cover property (evt_valid && evt_ready);
  c_stall: cover property (evt_valid && !evt_ready);
  c_bad: cover property (ind_state[0] == 4'h8);
endmodule // cin_monitor_chk
bind cin_monitor cin_monitor_chk #(.MS_CYCLES(MS_CYCLES)) u_cin_monitor_chk (.clock(clock), .nrst(nrst), .di(di),
  .ind_state(ind_state), .evt_valid(evt_valid), .evt_ready(evt_ready), .evt_data(evt_data), .ms_time(ms_time));
`default_nettype wire

// *** bench/tb_cin_monitor.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb_cin_monitor
  import cin_pkg::*;
;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic setup_mode = 1'b0;
  logic cfg_wr = 1'b0;
  logic [INST_W-1:0] cfg_inst = 4'h0;
  cin_cfg_type cfg_data = '0;
  logic [1:0] pos = 2'h0;
  logic single = 1'b0;
  logic evt_ready = 1'b1;
  logic [INST_W-1:0] rd_inst = 4'h9;
  logic [LABEL_IDX_W-1:0] rd_idx = 5'h0;
  logic label_wr = 1'b0;
  logic [INST_W-1:0] label_inst = 4'h0;
  logic [LABEL_IDX_W-1:0] label_idx = 5'h0;
  logic [CHAR_W-1:0] label_char = 8'h0;
  logic [DI_W-1:0] di;
  logic [SW_W-1:0] sw;
  logic [CHAR_W-1:0] rd_char;
  logic [NUM_INST-1:0][NUM_SIG-1:0] ind_state;
  logic evt_valid;
  cin_evt_type evt_data;
  logic [STAMP_W-1:0] ms_time;
  cin_evt_type q[$];
  int errors = 0;
  int n_tests = 0;
  int cyc = 0;
  always #20 clock = ~clock;
  cin_monitor #(.MS_CYCLES(4)) u_cin_monitor (.clock(clock), .nrst(nrst), .setup_mode(setup_mode), .cfg_wr(cfg_wr),
    .cfg_inst(cfg_inst), .cfg_data(cfg_data), .di(di), .software_signal(sw), .label_wr(label_wr),
    .label_inst(label_inst), .label_idx(label_idx), .label_char(label_char), .label_rd_inst(rd_inst),
    .label_rd_idx(rd_idx), .label_rd_char(rd_char),
    .ind_state(ind_state), .evt_valid(evt_valid), .evt_ready(evt_ready), .evt_data(evt_data), .ms_time(ms_time));
  cin_contacts u_cin_contacts (.pos(pos), .single(single), .di(di), .software_signal(sw));
  always @(posedge clock) if (evt_valid === 1'b1 && evt_ready === 1'b1) q.push_back(evt_data);
  task automatic results;
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge clock) begin
    cyc++;
    if (cyc == 2000) begin
      errors++;
      results;
    end
  end
  task automatic chk_st(input string nm, input logic [3:0] e, input logic [3:0] g);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_w(input string nm, input logic [38:0] e, input logic [38:0] g);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic w(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic cfgw(input logic sm, input logic [3:0] i, input cin_cfg_type d);
    setup_mode <= sm;
    cfg_inst <= i;
    cfg_data <= d;
    cfg_wr <= 1'b1;
    w(1);
    cfg_wr <= 1'b0;
    setup_mode <= 1'b0;
    w(6);
  endtask
  // Stamp is left out; event identity is compared
  task automatic pop(input logic [3:0] i, input logic [1:0] s, input logic on);
    cin_evt_type g;
    g = (q.size() > 0) ? q.pop_front() : 'x;
    chk_w("event", {i, s, on, 32'h0}, {g[38:32], 32'h0});
  endtask
  task automatic t_decode;
    logic [1:0] o;
    logic [1:0] lo;
    o = 2'h0;
    for (int p = 1; p < 5; p++) begin
      pos <= 2'(p);
      w(10);
      chk_st("state", 4'h1 << 2'(p), ind_state[0]);
      lo = (o < 2'(p)) ? o : 2'(p);
      pop(4'h0, lo, lo != o);
      pop(4'h0, lo ^ o ^ 2'(p), lo == o);
      o = 2'(p);
    end
    $display("test decode done");
  endtask
  task automatic t_stall;
    evt_ready <= 1'b0;
    pos <= 2'h1;
    w(10);
    chk_st("held", 4'h1, {3'h0, evt_valid});
    chk_st("count", 4'h0, 4'(q.size()));
    evt_ready <= 1'b1;
    w(6);
    pop(4'h0, 2'h0, 1'b0);
    pop(4'h0, 2'h1, 1'b1);
    pos <= 2'h0;
    w(8);
    q.delete();
    $display("test stall done");
  endtask
  task automatic t_filter;
    cfgw(1'b1, 4'h0, '{1'b0, 5'h0, 1'b0, 5'h1, 4'h2, 4'h0});
    pos <= 2'h1;
    w(8);
    pos <= 2'h0;
    w(8);
    chk_st("count", 4'h1, 4'(q.size()));
    pop(4'h0, 2'h1, 1'b1);
    $display("test filter done");
  endtask
  task automatic t_single;
    cfgw(1'b1, 4'h1, '{1'b0, 5'h2, 1'b1, 5'h0, 4'hF, 4'hF});
    q.delete();
    single <= 1'b1;
    w(8);
    chk_st("single", 4'h2, ind_state[1]);
    pop(4'h1, 2'h1, 1'b1);
    pop(4'h1, 2'h2, 1'b0);
    cfgw(1'b0, 4'h1, '{1'b1, 5'h0, 1'b0, 5'h2, 4'hF, 4'hF});
    single <= 1'b0;
    w(8);
    chk_st("locked", 4'h4, ind_state[1]);
    $display("test single done");
  endtask
  task automatic t_misc;
    logic [STAMP_W-1:0] m;
    logic [7:0] e [6] = '{LBL_CH0, LBL_CH1, LBL_CH2, LBL_DIGIT1, LBL_DIGIT0, LBL_PAD};
    m = ms_time;
    w(8);
    chk_w("ms", 39'(m + 32'h2), 39'(ms_time));
    for (int k = 0; k < 6; k++) begin
      rd_idx <= 5'(k);
      w(2);
      chk_w("label", 39'(e[k]), 39'(rd_char));
    end
    $display("test misc done");
  endtask
  // Second write arrives after setup has ended and must be refused
  task automatic t_label;
    setup_mode <= 1'b1;
    label_wr <= 1'b1;
    label_inst <= 4'h0;
    label_idx <= 5'h1;
    label_char <= 8'h41;
    w(1);
    setup_mode <= 1'b0;
    label_idx <= 5'h2;
    label_char <= 8'h42;
    w(1);
    label_wr <= 1'b0;
    rd_inst <= 4'h0;
    rd_idx <= 5'h1;
    w(2);
    chk_w("label", 39'h41, 39'(rd_char));
    rd_idx <= 5'h2;
    w(2);
    chk_w("label", 39'(LBL_PAD), 39'(rd_char));
    rd_idx <= 5'h0;
    w(2);
    chk_w("label", 39'(LBL_PAD), 39'(rd_char));
    $display("test label done");
  endtask
  initial begin
    w(6);
    nrst <= 1'b1;
    w(4);
    t_decode;
    t_stall;
    t_filter;
    t_single;
    t_misc;
    t_label;
    results;
  end
endmodule // tb_cin_monitor
`default_nettype wire
